// ---- sysrc_cfg.svh ----
`ifndef SYSRC_CFG_SVH
`define SYSRC_CFG_SVH

// ----------------------------------------------------------------
// Timing counts in sys_clk cycles
// ----------------------------------------------------------------
`define SYSRC_TMR_W          13
`define SYSRC_RESET_WAKE_CYC 13'h0100
`define SYSRC_IRC_WAKE_CYC   13'h0004
`define SYSRC_XTAL_WAKE_CYC  13'h1000

// ----------------------------------------------------------------
// Guard patterns read from the dedicated flash word
// ----------------------------------------------------------------
`define SYSRC_GUARD_ONE_PAT   32'h5A5A_1111
`define SYSRC_GUARD_TWO_PAT   32'h5A5A_2222
`define SYSRC_GUARD_THREE_PAT 32'h5A5A_3333

// ----------------------------------------------------------------
// Vector table placement
// ----------------------------------------------------------------
`define SYSRC_VT_ALIGN_MSB 8
`define SYSRC_VT_TOP_LSB   30

`endif

// ---- sysrc_pkg.sv ----
package sysrc_pkg;

   // ----------------------------------------------------------------
   // Sequencer states, Gray along the usual path
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_HOLD  = 3'h0,
      ST_OSC   = 3'h1,
      ST_COUNT = 3'h3,
      ST_FLASH = 3'h2,
      ST_RUN   = 3'h6,
      ST_WAKE  = 3'h7
   } sysrc_state_t;

   typedef enum logic [1:0] {
      GUARD_NONE  = 2'h0,
      GUARD_ONE   = 2'h1,
      GUARD_TWO   = 2'h2,
      GUARD_THREE = 2'h3
   } sysrc_guard_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic hold;
   } sysrc_sync_t;

   typedef struct packed {
      logic [12:0] cnt;
      logic        busy;
      logic        done;
   } sysrc_tmr_t;

endpackage

// ---- sysrc_tmr_if.sv ----
`timescale 1ns/1ns
`include "sysrc_cfg.svh"

interface sysrc_tmr_if;
   logic                     load;
   logic [`SYSRC_TMR_W-1:0]  count;
   logic                     done;

   modport ctl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

// ---- sysrc_wake_timer.sv ----
`timescale 1ns/1ns
`include "sysrc_cfg.svh"

module sysrc_wake_timer
   import sysrc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control side
   sysrc_tmr_if.tmr t
);

   sysrc_tmr_t q;
   sysrc_tmr_t next_q;

   // ----------------------------------------------------------------
   // Down counter, done pulses once after the loaded count
   // ----------------------------------------------------------------
   always_comb begin
      next_q      = q;
      next_q.done = 1'b0;
      if (t.load) begin
         next_q.cnt  = t.count;
         next_q.busy = 1'b1;
      end else if (q.busy) begin
         if (q.cnt <= 13'h0001) begin
            next_q.busy = 1'b0;
            next_q.done = 1'b1;
         end else begin
            next_q.cnt = q.cnt - 13'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign t.done = q.done;

   property p_done_single;
      @(posedge sys_clk) disable iff (rst)
      q.done |=> !q.done;
   endproperty
   a_done_single: assert property (p_done_single) else $error("timer done longer than one cycle");

endmodule // sysrc_wake_timer

// ---- sysrc_ctrl.sv ----
`timescale 1ns/1ns
`include "sysrc_cfg.svh"


module sysrc_ctrl
   import sysrc_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Reset sources
   input  wire logic        ext_reset_n,
   input  wire logic        watchdog_timeout,
   input  wire logic        power_on_detect,
   // Supply droop comparators
   input  wire logic        droop_below_upper,
   input  wire logic        droop_below_lower,
   input  wire logic        droop_irq_enable,
   // Start-up conditions
   input  wire logic        osc_running,
   input  wire logic        flash_init_done,
   // Guard word and loader
   input  wire logic [31:0] guard_word,
   input  wire logic        guard_word_valid,
   input  wire logic        loader_entry_pin,
   input  wire logic        loader_reinvoke,
   // Power modes
   input  wire logic        power_down,
   input  wire logic        level_irq,
   input  wire logic        level_wake_enable,
   input  wire logic        deep_sleep_wake,
   input  wire logic        irc_selected,
   // Vector table offset
   input  wire logic [31:0] vtor_value,
   input  wire logic        vtor_write,
   // Reset outputs
   output logic             chip_reset,
   output logic             periph_reset,
   output logic             fetch_start,
   output logic             boot_remap,
   // Droop outputs
   output logic             droop_irq,
   output logic             droop_irq_cpu,
   output logic             droop_status,
   output logic             flash_write_inhibit,
   // Guard outputs
   output sysrc_guard_t     guard_level,
   output logic             debug_enable,
   output logic             loader_active,
   output logic             loader_write_ok,
   output logic             loader_sector0_ok,
   output logic             loader_sector_erase_ok,
   output logic             loader_chip_erase_ok,
   output logic             app_flash_ok,
   // Power and vector outputs
   output logic             wake_request,
   output logic             resume,
   output logic             vtor_fault
);

   typedef struct packed {
      sysrc_state_t st;
      logic         periph_reset;
      logic         fetch_start;
      logic         boot_remap;
      logic         droop_irq;
      logic         droop_irq_cpu;
      logic         droop_status;
      logic         flash_inhibit;
      sysrc_guard_t lvl;
      logic         debug_en;
      logic         loader_act;
      logic         wr_ok;
      logic         s0_ok;
      logic         serase_ok;
      logic         cerase_ok;
      logic         app_ok;
      logic         wake_req;
      logic         resume;
      logic         vtor_fault;
      logic         tmr_load;
      logic [12:0]  tmr_count;
   } sysrc_main_t;

   sysrc_main_t q;
   sysrc_main_t next_q;
   sysrc_sync_t rs;
   logic        any_src;
   logic        cpu_live;

   sysrc_tmr_if tmr_bus ();

   sysrc_wake_timer u_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .t       (tmr_bus)
   );

   function automatic sysrc_guard_t guard_decode(input logic [31:0] w);
      if (w == `SYSRC_GUARD_ONE_PAT) begin
         return GUARD_ONE;
      end else if (w == `SYSRC_GUARD_TWO_PAT) begin
         return GUARD_TWO;
      end else if (w == `SYSRC_GUARD_THREE_PAT) begin
         return GUARD_THREE;
      end else begin
         return GUARD_NONE;
      end
   endfunction

   // ----------------------------------------------------------------
   // Reset sources and release synchroniser
   // ----------------------------------------------------------------
   assign any_src  = rst | ~ext_reset_n | watchdog_timeout | power_on_detect
                     | droop_below_lower;
   assign cpu_live = (q.st == ST_RUN) || (q.st == ST_WAKE);

   always_ff @(posedge sys_clk or posedge any_src) begin
      if (any_src) begin
         rs <= '1;
      end else begin
         rs.s1   <= 1'b0;
         rs.s2   <= rs.s1;
         rs.hold <= ~cpu_live;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer and status
   // ----------------------------------------------------------------
   always_comb begin
      next_q               = q;
      next_q.fetch_start   = 1'b0;
      next_q.resume        = 1'b0;
      next_q.tmr_load      = 1'b0;
      next_q.droop_irq     = droop_below_upper;
      next_q.droop_status  = droop_below_upper;
      next_q.droop_irq_cpu = droop_below_upper & droop_irq_enable;
      next_q.flash_inhibit = droop_below_lower | rs.hold;
      next_q.periph_reset  = rs.hold;
      next_q.app_ok        = 1'b1;
      next_q.wake_req      = power_down & level_wake_enable & level_irq;
      if (vtor_write) begin
         next_q.vtor_fault = (vtor_value[`SYSRC_VT_ALIGN_MSB:0] != '0)
                             || (vtor_value[31:`SYSRC_VT_TOP_LSB] != '0);
      end
      if (rs.s2) begin
         next_q.st         = ST_HOLD;
         next_q.boot_remap = 1'b1;
      end else begin
         case (q.st)
            ST_HOLD: begin
               next_q.st = ST_OSC;
            end
            ST_OSC: begin
               if (osc_running) begin
                  next_q.st        = ST_COUNT;
                  next_q.tmr_load  = 1'b1;
                  next_q.tmr_count = `SYSRC_RESET_WAKE_CYC;
               end
            end
            ST_COUNT: begin
               if (tmr_bus.done) begin
                  next_q.st = ST_FLASH;
               end
            end
            ST_FLASH: begin
               if (guard_word_valid) begin
                  next_q.lvl = guard_decode(guard_word);
               end
               if (flash_init_done) begin
                  next_q.st          = ST_RUN;
                  next_q.fetch_start = 1'b1;
                  next_q.loader_act  = loader_entry_pin && (next_q.lvl != GUARD_THREE);
               end
            end
            ST_RUN: begin
               if (deep_sleep_wake) begin
                  next_q.st        = ST_WAKE;
                  next_q.tmr_load  = 1'b1;
                  next_q.tmr_count = irc_selected ? `SYSRC_IRC_WAKE_CYC
                                                  : `SYSRC_XTAL_WAKE_CYC;
               end
            end
            default: begin
               if (tmr_bus.done) begin
                  next_q.st     = ST_RUN;
                  next_q.resume = 1'b1;
               end
            end
         endcase
      end
      if (loader_reinvoke && cpu_live) begin
         next_q.loader_act = 1'b1;
      end
      next_q.debug_en  = (next_q.lvl == GUARD_NONE);
      next_q.wr_ok     = next_q.loader_act;
      next_q.s0_ok     = next_q.loader_act && (next_q.lvl != GUARD_ONE);
      next_q.serase_ok = next_q.loader_act
                         && (next_q.lvl != GUARD_TWO);
      next_q.cerase_ok = next_q.loader_act && (next_q.lvl != GUARD_ONE);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q              <= '0;
         q.st           <= ST_HOLD;
         q.periph_reset <= 1'b1;
         q.boot_remap   <= 1'b1;
         q.flash_inhibit <= 1'b1;
         q.app_ok       <= 1'b1;
         q.lvl          <= GUARD_NONE;
      end else begin
         q <= next_q;
      end
   end

   assign tmr_bus.load  = q.tmr_load;
   assign tmr_bus.count = q.tmr_count;

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign chip_reset             = rs.hold;
   assign periph_reset           = q.periph_reset;
   assign fetch_start            = q.fetch_start;
   assign boot_remap             = q.boot_remap;
   assign droop_irq              = q.droop_irq;
   assign droop_irq_cpu          = q.droop_irq_cpu;
   assign droop_status           = q.droop_status;
   assign flash_write_inhibit    = q.flash_inhibit;
   assign guard_level            = q.lvl;
   assign debug_enable           = q.debug_en;
   assign loader_active          = q.loader_act;
   assign loader_write_ok        = q.wr_ok;
   assign loader_sector0_ok      = q.s0_ok;
   assign loader_sector_erase_ok = q.serase_ok;
   assign loader_chip_erase_ok   = q.cerase_ok;
   assign app_flash_ok           = q.app_ok;
   assign wake_request           = q.wake_req;
   assign resume                 = q.resume;
   assign vtor_fault             = q.vtor_fault;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_irc_wake;
      (q.st == ST_RUN) && !rs.s2 && deep_sleep_wake && irc_selected;
   endsequence

   property p_src_reset;
      @(posedge sys_clk) disable iff (rst)
      (!ext_reset_n || watchdog_timeout || power_on_detect) |-> chip_reset;
   endproperty
   a_src_reset: assert property (p_src_reset) else $error("source without reset");

   property p_hold_flash;
      @(posedge sys_clk) disable iff (rst)
      (chip_reset && !flash_init_done) |=> chip_reset;
   endproperty
   a_hold_flash: assert property (p_hold_flash) else $error("released before flash");

   property p_release_fetch;
      @(posedge sys_clk) disable iff (rst)
      $fell(chip_reset) |-> $past(fetch_start) && boot_remap;
   endproperty
   a_release_fetch: assert property (p_release_fetch) else $error("no fetch at release");

   property p_periph;
      @(posedge sys_clk) disable iff (rst)
      $rose(chip_reset) |=> periph_reset;
   endproperty
   a_periph: assert property (p_periph) else $error("peripherals not in reset");

   property p_droop_irq;
      @(posedge sys_clk) disable iff (rst)
      droop_below_upper |=> droop_irq && droop_status;
   endproperty
   a_droop_irq: assert property (p_droop_irq) else $error("droop request missing");

   property p_droop_gate;
      @(posedge sys_clk) disable iff (rst)
      (droop_below_upper && !droop_irq_enable) |=> !droop_irq_cpu && droop_status;
   endproperty
   a_droop_gate: assert property (p_droop_gate) else $error("droop not gated");

   property p_deep_droop;
      @(posedge sys_clk) disable iff (rst)
      droop_below_lower |-> chip_reset ##1 flash_write_inhibit;
   endproperty
   a_deep_droop: assert property (p_deep_droop) else $error("deep droop ignored");

   property p_guard_debug;
      @(posedge sys_clk) disable iff (rst)
      (guard_level != GUARD_NONE) |-> !debug_enable;
   endproperty
   a_guard_debug: assert property (p_guard_debug) else $error("debug open");

   property p_guard_three;
      @(posedge sys_clk) disable iff (rst)
      (guard_level == GUARD_THREE && fetch_start) |-> !loader_active;
   endproperty
   a_guard_three: assert property (p_guard_three) else $error("loader open");

   property p_irc_wake;
      @(posedge sys_clk) disable iff (rst)
      s_irc_wake |=> !resume [*4] ##[1:4] resume;
   endproperty
   a_irc_wake: assert property (p_irc_wake) else $error("wake timing wrong");

endmodule // sysrc_ctrl

// ---- sysrc_far_side.sv ----
`timescale 1ns/1ns

module sysrc_far_side
   import sysrc_pkg::*;
(
   // Clock and chip reset seen
   input  wire logic        sys_clk,
   input  wire logic        chip_reset,
   // Test controls
   input  wire logic        slow,
   input  wire logic [31:0] pat,
   // Start-up answers
   output logic             osc_running,
   output logic             flash_init_done,
   output logic [31:0]      guard_word,
   output logic             guard_word_valid
);
   // ----------------------------------------------------------------
   // Oscillator and flash restart with every chip reset
   // ----------------------------------------------------------------
   int cnt;
   int dly;

   assign dly = slow ? 300 : 3;

   always @(posedge sys_clk) begin
      cnt <= chip_reset ? cnt + 1 : 0;
   end

   assign osc_running      = !chip_reset || cnt >= dly;
   assign flash_init_done  = !chip_reset || cnt >= dly + 2;
   assign guard_word_valid = flash_init_done;
   // Word not valid yet shows garbage
   assign guard_word       = guard_word_valid ? pat : ~pat;
endmodule // sysrc_far_side

// ---- tb_system_reset_brownout_crp_control.sv ----
`timescale 1ns/1ns
`include "sysrc_cfg.svh"

module tb_system_reset_brownout_crp_control;
   import sysrc_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic         sys_clk, rst, ext_reset_n, watchdog_timeout, power_on_detect;
   logic         droop_below_upper, droop_below_lower, droop_irq_enable;
   logic         osc_running, flash_init_done, guard_word_valid, slow;
   logic [31:0]  guard_word, vtor_value, pat;
   logic         loader_entry_pin, loader_reinvoke, power_down, level_irq;
   logic         level_wake_enable, deep_sleep_wake, irc_selected, vtor_write;
   logic         chip_reset, periph_reset, fetch_start, boot_remap;
   logic         droop_irq, droop_irq_cpu, droop_status, flash_write_inhibit;
   sysrc_guard_t guard_level;
   logic         debug_enable, loader_active, loader_write_ok, loader_sector0_ok;
   logic         loader_sector_erase_ok, loader_chip_erase_ok, app_flash_ok;
   logic         wake_request, resume, vtor_fault;
   int           n_fail, num_checks, cyc, nfs, n;
   logic [31:0]  vt [4] = '{32'h0000_0200, 32'h0000_0100, 32'h3FFF_FE00, 32'h4000_0000};

   sysrc_ctrl dut (.*);

   sysrc_far_side u_far (.sys_clk(sys_clk), .chip_reset(chip_reset), .slow(slow),
      .pat(pat), .osc_running(osc_running), .flash_init_done(flash_init_done),
      .guard_word(guard_word), .guard_word_valid(guard_word_valid));

   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task results;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         $display("BAD timeout exp 0 got 1");
         results;
      end
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task stp(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   task wait_rel(output int m);
      m = 0;
      while (chip_reset !== 1'b0 && m < 2000) begin
         if (fetch_start === 1'b1) nfs++;
         stp(1);
         m++;
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset_seq(input logic s, input int lo, input int hi);
      slow = s;
      ext_reset_n = 0;
      #2 chk("pin_async", 1, chip_reset);
      stp(20);
      ext_reset_n = 1;
      nfs = 0;
      wait_rel(n);
      chk("rel_not_early", 1, n >= lo);
      chk("rel_not_late", 1, n <= hi);
      chk("fetch_pulses", 1, nfs);
      chk("boot_remap", 1, boot_remap);
      chk("periph_hold", 1, periph_reset);
      stp(1);
      chk("periph_rel", 0, periph_reset);
      chk("fetch_once", 0, fetch_start);
      slow = 0;
      $display("test reset_seq done");
   endtask

   task t_sources;
      for (int i = 0; i < 4; i++) begin
         chk("run_before", 0, chip_reset);
         ext_reset_n = (i != 0);
         watchdog_timeout = (i == 1);
         power_on_detect = (i == 2);
         droop_below_lower = (i == 3);
         #2 chk("src_async", 1, chip_reset);
         stp(3);
         chk("flash_inhibit", 1, flash_write_inhibit);
         ext_reset_n = 1;
         watchdog_timeout = 0;
         power_on_detect = 0;
         droop_below_lower = 0;
         wait_rel(n);
         chk("src_release", 0, chip_reset);
      end
      $display("test sources done");
   endtask

   task t_droop;
      droop_below_upper = 1;
      stp(2);
      chk("droop_irq", 1, droop_irq);
      chk("droop_status", 1, droop_status);
      chk("irq_masked", 0, droop_irq_cpu);
      chk("run_kept", 0, chip_reset);
      droop_irq_enable = 1;
      stp(2);
      chk("irq_cpu", 1, droop_irq_cpu);
      droop_below_upper = 0;
      stp(2);
      chk("status_clear", 0, droop_status);
      chk("irq_cpu_clear", 0, droop_irq_cpu);
      droop_below_upper = 1;
      droop_below_lower = 1;
      #2 chk("deep_droop", 1, chip_reset);
      stp(2);
      power_on_detect = 1;
      stp(1);
      droop_below_lower = 0;
      droop_below_upper = 0;
      stp(10);
      chk("por_holds", 1, chip_reset);
      power_on_detect = 0;
      droop_irq_enable = 0;
      wait_rel(n);
      chk("droop_release", 0, chip_reset);
      $display("test droop done");
   endtask

   task t_guard(input logic [31:0] p, input sysrc_guard_t lv, input logic [4:0] e);
      pat = p;
      loader_entry_pin = 1;
      watchdog_timeout = 1;
      stp(2);
      watchdog_timeout = 0;
      wait_rel(n);
      loader_entry_pin = 0;
      stp(1);
      chk("guard_level", lv, guard_level);
      chk("perms", e, {debug_enable, loader_active, loader_sector0_ok,
                       loader_sector_erase_ok, loader_chip_erase_ok});
      chk("write_ok", lv != GUARD_THREE, loader_write_ok);
      chk("app_ok", 1, app_flash_ok);
      loader_reinvoke = 1;
      stp(1);
      loader_reinvoke = 0;
      stp(2);
      chk("reinvoke", 1, loader_active);
      $display("test guard done");
   endtask

   task t_wake;
      power_down = 1;
      level_irq = 1;
      stp(2);
      chk("wake_off", 0, wake_request);
      level_wake_enable = 1;
      stp(2);
      chk("wake_on", 1, wake_request);
      power_down = 0;
      level_wake_enable = 0;
      level_irq = 0;
      for (int i = 0; i < 2; i++) begin
         irc_selected = (i == 0);
         deep_sleep_wake = 1;
         stp(1);
         deep_sleep_wake = 0;
         n = 1;
         while (resume !== 1'b1 && n < 5000) begin
            stp(1);
            n++;
         end
         chk("resume_min", 1, n >= (i ? 4096 : 4));
         chk("resume_max", 1, n <= (i ? 4106 : 10));
         stp(1);
         chk("resume_pulse", 0, resume);
      end
      $display("test wake done");
   endtask

   task t_vtor;
      for (int i = 0; i < 4; i++) begin
         vtor_value = vt[i];
         vtor_write = 1;
         stp(1);
         vtor_write = 0;
         stp(2);
         chk("vtor_fault", i % 2, vtor_fault);
      end
      $display("test vtor done");
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1;
      ext_reset_n = 1;
      {watchdog_timeout, power_on_detect, droop_below_upper, droop_below_lower} = '0;
      {droop_irq_enable, loader_entry_pin, loader_reinvoke, power_down} = '0;
      {level_irq, level_wake_enable, deep_sleep_wake, irc_selected} = '0;
      vtor_value = 32'h0000_0000;
      vtor_write = 0;
      pat = 32'h0000_0000;
      slow = 0;
      repeat (5) @(posedge sys_clk);
      #1 rst = 0;
      wait_rel(n);
      chk("boot_release", 0, chip_reset);
      t_reset_seq(0, 258, 275);
      t_reset_seq(1, 530, 570);
      t_sources;
      t_droop;
      t_guard(32'h5A5A_1112, GUARD_NONE, 5'h1F);
      t_guard(`SYSRC_GUARD_ONE_PAT, GUARD_ONE, 5'h0A);
      t_guard(`SYSRC_GUARD_TWO_PAT, GUARD_TWO, 5'h0D);
      t_guard(`SYSRC_GUARD_THREE_PAT, GUARD_THREE, 5'h00);
      t_wake;
      t_vtor;
      results;
   end
endmodule // tb_system_reset_brownout_crp_control
